// file: include/ccdp_regs.vh
`ifndef CCDP_REGS_VH
`define CCDP_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CCDP_ADDR_W             10
`define CCDP_DIV0_PHASE_ADDR    10'h190
`define CCDP_DIV0_CTRL_ADDR     10'h191
`define CCDP_CH0_PWR_ADDR       10'h192
`define CCDP_DIV1_PHASE_ADDR    10'h193
`define CCDP_DIV1_CTRL_ADDR     10'h194

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CCDP_LOW_MSB            7
`define CCDP_LOW_LSB            4
`define CCDP_HIGH_MSB           3
`define CCDP_HIGH_LSB           0
`define CCDP_BYPASS_BIT         7
`define CCDP_IGN_SYNC_BIT       6
`define CCDP_FORCE_BIT          5
`define CCDP_START_BIT          4
`define CCDP_PHASE_MSB          3
`define CCDP_PHASE_LSB          0
`define CCDP_PWR_DN_BIT         2
`define CCDP_DCC_DIS_BIT        0

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define CCDP_DIV0_PHASE_RST     8'h77
`define CCDP_DIV0_CTRL_RST      8'h00
`define CCDP_CH0_PWR_RST        8'h00
`define CCDP_DIV1_PHASE_RST     8'h33
`define CCDP_DIV1_CTRL_RST      8'h00
`define CCDP_CH0_PWR_MASK       8'h05
`define CCDP_DIV1_CTRL_MASK     8'hC0

// ----------------------------------------------------------------------
// Divider states
// ----------------------------------------------------------------------
`define CCDP_ST_HOLD            2'h0
`define CCDP_ST_DLY             2'h1
`define CCDP_ST_RUN             2'h2

`endif

// file: sim/ccdp_clk_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Downstream receiver of one divided clock
// ----------------------------------------
module ccdp_clk_sink (
    input  wire logic        core_clk,
    input  wire logic        clk_in,
    output var  logic [7:0]  hi_len,
    output var  logic [7:0]  lo_len,
    output var  logic [7:0]  run,
    output var  logic [15:0] rise_at
);
    logic        last;
    logic [15:0] now;
    initial begin
        last = 1'b0;
        now = 16'h0000;
        hi_len = 8'h00;
        lo_len = 8'h00;
        run = 8'h00;
        rise_at = 16'h0000;
    end
    always @(posedge core_clk) begin
        now <= now + 16'h0001;
        last <= clk_in;
        if (clk_in !== last) begin
            if (last)
                hi_len <= run;
            else
                lo_len <= run;
            if (clk_in)
                rise_at <= now;
            run <= 8'h01;
        end else if (run != 8'hFF)
            run <= run + 8'h01;
    end
endmodule
`default_nettype wire

// file: sim/ccdp_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checks
// ----------------------------------------
module ccdp_top_checker #(
    parameter AW = 10,
    parameter FW = 4
) (
    input wire logic          core_clk,
    input wire logic          rstn,
    input wire logic [AW-1:0] reg_addr,
    input wire logic          reg_rd,
    input wire logic [7:0]    reg_rdata,
    input wire logic          reg_rvalid,
    input wire logic          channel0_output_a_p,
    input wire logic          channel0_output_a_n,
    input wire logic          channel0_output_a_oe,
    input wire logic          channel0_output_b_p,
    input wire logic          channel0_output_b_n,
    input wire logic          channel0_output_b_oe,
    input wire logic          channel0_output_c_p,
    input wire logic          channel0_output_c_n,
    input wire logic          channel0_output_c_oe,
    input wire logic          channel1_output
);
    logic [4:0] hi_cnt_ff;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Divider 1 cannot be forced, so a long high run is a count fault
    always @(posedge core_clk) begin
        if (!rstn || !channel1_output)
            hi_cnt_ff <= 5'h00;
        else if (hi_cnt_ff != 5'h1F)
            hi_cnt_ff <= hi_cnt_ff + 5'h01;
    end
    rd_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read valid without a read");
    unmapped_zero_a: assert property (reg_rd && (reg_addr < 'h190 || reg_addr > 'h194)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    ctrl1_mask_a: assert property (reg_rd && reg_addr == 'h194 |=> reg_rdata[5:0] == 6'h00)
        else $error("divider 1 control unused bits set");
    pwr_mask_a: assert property (reg_rd && reg_addr == 'h192 |=> (reg_rdata & 8'hFA) == 8'h00)
        else $error("power register unused bits set");
    pair_compl_a: assert property (channel0_output_a_oe |-> channel0_output_a_n != channel0_output_a_p)
        else $error("pair A not complementary");
    hiz_quiet_a: assert property (!channel0_output_a_oe |-> !(channel0_output_a_p | channel0_output_a_n
        | channel0_output_b_p | channel0_output_b_n | channel0_output_c_p | channel0_output_c_n))
        else $error("pins active while disabled");
    pairs_agree_a: assert property (channel0_output_a_p == channel0_output_b_p
        && channel0_output_b_p == channel0_output_c_p && channel0_output_a_oe == channel0_output_b_oe
        && channel0_output_b_oe == channel0_output_c_oe) else $error("channel 0 pairs differ");
    ch1_high_max_a: assert property (hi_cnt_ff <= 5'h10)
        else $error("divider 1 high phase too long");
endmodule

bind ccdp_top ccdp_top_checker #(.AW(AW), .FW(FW)) u_chk (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .channel0_output_a_p(channel0_output_a_p),
    .channel0_output_a_n(channel0_output_a_n), .channel0_output_a_oe(channel0_output_a_oe),
    .channel0_output_b_p(channel0_output_b_p), .channel0_output_b_n(channel0_output_b_n),
    .channel0_output_b_oe(channel0_output_b_oe), .channel0_output_c_p(channel0_output_c_p),
    .channel0_output_c_n(channel0_output_c_n), .channel0_output_c_oe(channel0_output_c_oe),
    .channel1_output(channel1_output));
`default_nettype wire

// file: sim/channel_clock_divider_pair_bench.sv
`timescale 1ns/1ps
`default_nettype none
module channel_clock_divider_pair_bench;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        sync_n = 1'b1;
    logic [9:0]  reg_addr = 10'h000;
    logic [7:0]  reg_wdata = 8'h00;
    wire  [7:0]  reg_rdata, h0, l0, r0, h1, l1, r1;
    wire  [15:0] t0, t1;
    wire         reg_rvalid, a_p, a_n, a_oe, b_p, b_n, b_oe, c_p, c_n, c_oe, ch1, run0, run1;
    int          fails = 0;
    int          checked = 0;

    always #50 core_clk = ~core_clk;

    ccdp_top DUT (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sync_n(sync_n), .channel0_output_a_p(a_p), .channel0_output_a_n(a_n),
        .channel0_output_a_oe(a_oe), .channel0_output_b_p(b_p), .channel0_output_b_n(b_n),
        .channel0_output_b_oe(b_oe), .channel0_output_c_p(c_p), .channel0_output_c_n(c_n),
        .channel0_output_c_oe(c_oe), .channel1_output(ch1), .div0_running(run0),
        .div1_running(run1));
    ccdp_clk_sink sink0 (.core_clk(core_clk), .clk_in(a_p), .hi_len(h0), .lo_len(l0), .run(r0),
        .rise_at(t0));
    ccdp_clk_sink sink1 (.core_clk(core_clk), .clk_in(ch1), .hi_len(h1), .lo_len(l1), .run(r1),
        .rise_at(t1));

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Answer is registered: valid and data appear at the edge after the strobe
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("rvalid", 16'(reg_rvalid), 16'h0001);
        chk("rdata", 16'(reg_rdata), 16'(exp));
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic ph(input string w, input logic [7:0] h, l, eh, el);
        chk({w, " high"}, 16'(h), 16'(eh));
        chk({w, " low"}, 16'(l), 16'(el));
    endtask
    task automatic conclude;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        rd(10'h190, 8'h77);
        rd(10'h191, 8'h00);
        rd(10'h192, 8'h00);
        rd(10'h193, 8'h33);
        rd(10'h194, 8'h00);
        rd(10'h18F, 8'h00);
        idle(70);
        ph("div0 reset", h0, l0, 8'h08, 8'h08);
        ph("div1 reset", h1, l1, 8'h04, 8'h04);
        wr(10'h190, 8'h52);
        idle(70);
        ph("div0 corrected", h0, l0, 8'h04, 8'h05);
        wr(10'h192, 8'h01);
        idle(70);
        ph("div0 raw", h0, l0, 8'h03, 8'h06);
        wr(10'h192, 8'hFF);
        rd(10'h192, 8'h05);
        idle(4);
        chk("powered down", 16'({a_oe, b_oe, c_oe, a_p, a_n}), 16'h0000);
        wr(10'h192, 8'h00);
        wr(10'h194, 8'hFF);
        rd(10'h194, 8'hC0);
        idle(20);
        ph("div1 bypass", h1, l1, 8'h01, 8'h01);
        wr(10'h194, 8'h00);
        wr(10'h191, 8'h80);
        idle(20);
        ph("div0 bypass", h0, l0, 8'h01, 8'h01);
        // Force without ignore-sync must not freeze the output
        wr(10'h191, 8'h20);
        idle(70);
        ph("force alone", h0, l0, 8'h04, 8'h05);
        wr(10'h191, 8'h60);
        idle(40);
        chk("forced high", 16'({a_p, r0 > 8'h1E}), 16'h0003);
        wr(10'h191, 8'h10);
        sync_n <= 1'b0;
        idle(30);
        chk("held at start", 16'({a_p, run0, run1, ch1}), 16'h0008);
        wr(10'h191, 8'h50);
        idle(70);
        ph("sync ignored", h0, l0, 8'h04, 8'h05);
        wr(10'h190, 8'h33);
        wr(10'h191, 8'h03);
        idle(20);
        @(posedge core_clk);
        sync_n <= 1'b1;
        idle(60);
        // Equal ratios of eight, so the rise stamps differ by the offset modulo eight
        chk("stagger", 16'(3'(t0 - t1)), 16'h0003);
        chk("running", 16'({run0, run1}), 16'h0003);
        conclude();
    end
endmodule
`default_nettype wire

// file: verilog/ccdp_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "ccdp_regs.vh"

module ccdp_divider #(
    parameter CW = 4
) (
    input  wire          core_clk,
    input  wire          rstn,
    input  wire [CW-1:0] low_len,
    input  wire [CW-1:0] high_len,
    input  wire          bypass,
    input  wire          ignore_sync,
    input  wire          sync_act,
    input  wire          force_lvl,
    input  wire          start_high,
    input  wire [CW-1:0] phase_off,
    input  wire          dcc_en,
    input  wire          pwr_dn,
    output wire          div_out,
    output wire          running
);

    reg  [1:0]    state_ff;
    reg  [1:0]    nxt_state;
    reg  [CW+1:0] cnt_ff;
    reg  [CW+1:0] nxt_cnt;
    reg           out_ff;
    reg           nxt_out;

    // ------------------------------------------------------------------
    // Phase lengths, with odd totals split as evenly as whole cycles allow
    // ------------------------------------------------------------------
    wire [CW+1:0] one_c    = {{(CW+1){1'b0}}, 1'b1};
    wire [CW+1:0] lo_raw   = {2'b00, low_len} + one_c;
    wire [CW+1:0] hi_raw   = {2'b00, high_len} + one_c;
    wire [CW+1:0] total    = lo_raw + hi_raw;
    wire [CW+1:0] hi_half  = total >> 1;
    wire [CW+1:0] lo_half  = total - hi_half;
    wire          fix_duty = dcc_en & total[0];
    wire [CW+1:0] hi_eff   = fix_duty ? hi_half : hi_raw;
    wire [CW+1:0] lo_eff   = fix_duty ? lo_half : lo_raw;
    wire [CW+1:0] cur_len  = out_ff ? hi_eff : lo_eff;
    wire [CW+1:0] dly_len  = {2'b00, phase_off};
    wire          hold     = sync_act & ~ignore_sync;
    wire          forced   = ignore_sync & force_lvl;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_out   = out_ff;
        if (pwr_dn) begin
            nxt_state = `CCDP_ST_HOLD;
            nxt_cnt   = {(CW+2){1'b0}};
            nxt_out   = 1'b0;
        end else if (bypass) begin
            // Counter parked; output toggles every input cycle, half the input rate
            nxt_state = `CCDP_ST_HOLD;
            nxt_cnt   = {(CW+2){1'b0}};
            nxt_out   = ~out_ff;
        end else if (forced) begin
            nxt_state = `CCDP_ST_HOLD;
            nxt_cnt   = {(CW+2){1'b0}};
            nxt_out   = 1'b1;
        end else if (hold) begin
            nxt_state = `CCDP_ST_HOLD;
            nxt_cnt   = {(CW+2){1'b0}};
            nxt_out   = start_high;
        end else begin
            case (state_ff)
                `CCDP_ST_HOLD: begin
                    nxt_out = start_high;
                    nxt_cnt = {(CW+2){1'b0}};
                    if (phase_off == {CW{1'b0}}) begin
                        nxt_state = `CCDP_ST_RUN;
                    end else begin
                        nxt_state = `CCDP_ST_DLY;
                    end
                end
                `CCDP_ST_DLY: begin
                    if (cnt_ff + one_c >= dly_len) begin
                        nxt_state = `CCDP_ST_RUN;
                        nxt_cnt   = {(CW+2){1'b0}};
                    end else begin
                        nxt_cnt = cnt_ff + one_c;
                    end
                end
                `CCDP_ST_RUN: begin
                    // A length shortened mid-phase ends the phase at once instead of wrapping
                    if (cnt_ff >= cur_len - one_c) begin
                        nxt_out = ~out_ff;
                        nxt_cnt = {(CW+2){1'b0}};
                    end else begin
                        nxt_cnt = cnt_ff + one_c;
                    end
                end
                default: begin
                    nxt_state = `CCDP_ST_HOLD;
                    nxt_cnt   = {(CW+2){1'b0}};
                end
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            state_ff <= `CCDP_ST_HOLD;
            cnt_ff   <= {(CW+2){1'b0}};
            out_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            out_ff   <= nxt_out;
        end
    end

    assign div_out = out_ff;
    assign running = (state_ff == `CCDP_ST_RUN);

endmodule

`default_nettype wire

// file: verilog/ccdp_top.v
`timescale 1ns/1ps
`default_nettype none
`include "ccdp_regs.vh"

// Notes on behaviour
// - Low phase lasts the upper nibble plus one input cycles.
// - High phase lasts the lower nibble plus one input cycles.
// - Divider 0 phase fields reset to seven each: eight low, eight high.
// - Divider 1 phase fields reset to three each: four low, four high.
// - Bypass bit parks the divider's counter and passes half the input rate out.
// - Sync holds the divider unless its ignore-sync bit is set.
// - Force bit sets divider 0 static; only acts with ignore-sync set.
// - Start-level bit picks the level divider 0 begins with.
// - Divider 0 phase offset is a four-bit field resetting to zero.
// - Channel 0 power-down stops divider 0 and tristates its three pairs.
// - Duty-cycle correction runs unless its disable bit is set.
module ccdp_top #(
    parameter AW = `CCDP_ADDR_W,
    parameter FW = 4
) (
    input  wire          core_clk,
    input  wire          rstn,
    input  wire [AW-1:0] reg_addr,
    input  wire [7:0]    reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output reg  [7:0]    reg_rdata,
    output reg           reg_rvalid,
    input  wire          sync_n,
    output reg           channel0_output_a_p,
    output reg           channel0_output_a_n,
    output reg           channel0_output_a_oe,
    output reg           channel0_output_b_p,
    output reg           channel0_output_b_n,
    output reg           channel0_output_b_oe,
    output reg           channel0_output_c_p,
    output reg           channel0_output_c_n,
    output reg           channel0_output_c_oe,
    output reg           channel1_output,
    output reg           div0_running,
    output reg           div1_running
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    reg  [7:0] divider0_phase_lengths_ff;
    reg  [7:0] divider0_control_ff;
    reg  [7:0] channel0_power_and_correction_ff;
    reg  [7:0] divider1_phase_lengths_ff;
    reg  [7:0] divider1_control_ff;
    reg  [7:0] nxt_rdata;

    // ------------------------------------------------------------------
    // Write decode; unmapped addresses fall through and are dropped
    // ------------------------------------------------------------------
    wire       wr_div0_phase = reg_wr & (reg_addr == `CCDP_DIV0_PHASE_ADDR);
    wire       wr_div0_ctrl  = reg_wr & (reg_addr == `CCDP_DIV0_CTRL_ADDR);
    wire       wr_ch0_pwr    = reg_wr & (reg_addr == `CCDP_CH0_PWR_ADDR);
    wire       wr_div1_phase = reg_wr & (reg_addr == `CCDP_DIV1_PHASE_ADDR);
    wire       wr_div1_ctrl  = reg_wr & (reg_addr == `CCDP_DIV1_CTRL_ADDR);

    always @(posedge core_clk) begin
        if (!rstn) begin
            divider0_phase_lengths_ff <= `CCDP_DIV0_PHASE_RST;
        end else if (wr_div0_phase) begin
            divider0_phase_lengths_ff <= reg_wdata;
        end
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            divider0_control_ff <= `CCDP_DIV0_CTRL_RST;
        end else if (wr_div0_ctrl) begin
            divider0_control_ff <= reg_wdata;
        end
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            channel0_power_and_correction_ff <= `CCDP_CH0_PWR_RST;
        end else if (wr_ch0_pwr) begin
            // Only power-down and correction-disable exist here
            channel0_power_and_correction_ff <= reg_wdata & `CCDP_CH0_PWR_MASK;
        end
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            divider1_phase_lengths_ff <= `CCDP_DIV1_PHASE_RST;
        end else if (wr_div1_phase) begin
            divider1_phase_lengths_ff <= reg_wdata;
        end
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            divider1_control_ff <= `CCDP_DIV1_CTRL_RST;
        end else if (wr_div1_ctrl) begin
            // Divider 1 keeps only bypass and ignore-sync in this map
            divider1_control_ff <= reg_wdata & `CCDP_DIV1_CTRL_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Read-back, one cycle after the strobe
    // ------------------------------------------------------------------
    // A read in the cycle of a write to the same address returns the old value
    always @* begin
        case (reg_addr)
            `CCDP_DIV0_PHASE_ADDR: begin
                nxt_rdata = divider0_phase_lengths_ff;
            end
            `CCDP_DIV0_CTRL_ADDR: begin
                nxt_rdata = divider0_control_ff;
            end
            `CCDP_CH0_PWR_ADDR: begin
                nxt_rdata = channel0_power_and_correction_ff;
            end
            `CCDP_DIV1_PHASE_ADDR: begin
                nxt_rdata = divider1_phase_lengths_ff;
            end
            `CCDP_DIV1_CTRL_ADDR: begin
                nxt_rdata = divider1_control_ff;
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= nxt_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sync pin: three stages, level changes once stages two and three agree
    // ------------------------------------------------------------------
    reg  sync_s1_ff;
    reg  sync_s2_ff;
    reg  sync_s3_ff;
    reg  sync_lvl_ff;

    // Stages reset to the released level so leaving reset never looks like a sync
    always @(posedge core_clk) begin
        if (!rstn) begin
            sync_s1_ff  <= 1'b1;
            sync_s2_ff  <= 1'b1;
            sync_s3_ff  <= 1'b1;
            sync_lvl_ff <= 1'b1;
        end else begin
            sync_s1_ff <= sync_n;
            sync_s2_ff <= sync_s1_ff;
            sync_s3_ff <= sync_s2_ff;
            if (sync_s2_ff == sync_s3_ff) begin
                sync_lvl_ff <= sync_s3_ff;
            end
        end
    end

    wire sync_act = ~sync_lvl_ff;

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    wire [FW-1:0] d0_low    = divider0_phase_lengths_ff[`CCDP_LOW_MSB:`CCDP_LOW_LSB];
    wire [FW-1:0] d0_high   = divider0_phase_lengths_ff[`CCDP_HIGH_MSB:`CCDP_HIGH_LSB];
    wire          d0_bypass = divider0_control_ff[`CCDP_BYPASS_BIT];
    wire          d0_ignore = divider0_control_ff[`CCDP_IGN_SYNC_BIT];
    wire          d0_force  = divider0_control_ff[`CCDP_FORCE_BIT];
    wire          d0_start  = divider0_control_ff[`CCDP_START_BIT];
    wire [FW-1:0] d0_phase  = divider0_control_ff[`CCDP_PHASE_MSB:`CCDP_PHASE_LSB];
    wire          ch0_pd    = channel0_power_and_correction_ff[`CCDP_PWR_DN_BIT];
    wire          d0_dcc    = ~channel0_power_and_correction_ff[`CCDP_DCC_DIS_BIT];
    wire [FW-1:0] d1_low    = divider1_phase_lengths_ff[`CCDP_LOW_MSB:`CCDP_LOW_LSB];
    wire [FW-1:0] d1_high   = divider1_phase_lengths_ff[`CCDP_HIGH_MSB:`CCDP_HIGH_LSB];
    wire          d1_bypass = divider1_control_ff[`CCDP_BYPASS_BIT];
    wire          d1_ignore = divider1_control_ff[`CCDP_IGN_SYNC_BIT];

    // ------------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------------
    wire div0_out;
    wire div0_run;
    wire div1_out;
    wire div1_run;

    ccdp_divider #(
        .CW          (FW)
    ) u_div0 (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .low_len     (d0_low),
        .high_len    (d0_high),
        .bypass      (d0_bypass),
        .ignore_sync (d0_ignore),
        .sync_act    (sync_act),
        .force_lvl   (d0_force),
        .start_high  (d0_start),
        .phase_off   (d0_phase),
        .dcc_en      (d0_dcc),
        .pwr_dn      (ch0_pd),
        .div_out     (div0_out),
        .running     (div0_run)
    );

    // Divider 1 has no force, start or offset controls in this map
    ccdp_divider #(
        .CW          (FW)
    ) u_div1 (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .low_len     (d1_low),
        .high_len    (d1_high),
        .bypass      (d1_bypass),
        .ignore_sync (d1_ignore),
        .sync_act    (sync_act),
        .force_lvl   (1'b0),
        .start_high  (1'b0),
        .phase_off   ({FW{1'b0}}),
        .dcc_en      (1'b1),
        .pwr_dn      (1'b0),
        .div_out     (div1_out),
        .running     (div1_run)
    );

    // ------------------------------------------------------------------
    // Output pairs; all three of channel 0 share one divider so they
    // stay skew-free relative to each other
    // ------------------------------------------------------------------
    wire ch0_drive = ~ch0_pd;

    // One enable gates both legs, so a powered-down pair shows no stray level
    always @(posedge core_clk) begin
        if (!rstn) begin
            channel0_output_a_p  <= 1'b0;
            channel0_output_a_n  <= 1'b0;
            channel0_output_a_oe <= 1'b0;
        end else begin
            channel0_output_a_p  <= ch0_drive & div0_out;
            channel0_output_a_n  <= ch0_drive & ~div0_out;
            channel0_output_a_oe <= ch0_drive;
        end
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            channel0_output_b_p  <= 1'b0;
            channel0_output_b_n  <= 1'b0;
            channel0_output_b_oe <= 1'b0;
        end else begin
            channel0_output_b_p  <= ch0_drive & div0_out;
            channel0_output_b_n  <= ch0_drive & ~div0_out;
            channel0_output_b_oe <= ch0_drive;
        end
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            channel0_output_c_p  <= 1'b0;
            channel0_output_c_n  <= 1'b0;
            channel0_output_c_oe <= 1'b0;
        end else begin
            channel0_output_c_p  <= ch0_drive & div0_out;
            channel0_output_c_n  <= ch0_drive & ~div0_out;
            channel0_output_c_oe <= ch0_drive;
        end
    end

    // ------------------------------------------------------------------
    // Channel 1 output and running flags
    // ------------------------------------------------------------------
    // Divider 1 has no power-down of its own here, so its pin always drives
    always @(posedge core_clk) begin
        if (!rstn) begin
            channel1_output <= 1'b0;
        end else begin
            channel1_output <= div1_out;
        end
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            div0_running <= 1'b0;
            div1_running <= 1'b0;
        end else begin
            div0_running <= div0_run;
            div1_running <= div1_run;
        end
    end

endmodule

`default_nettype wire
